// file: rtl/sdpmt_core.sv
// Clock-enable power state, internal clock gating and byte mask for one
// SDRAM. Assumes the controller drives mem_clk, cke, dqm and write data,
// all sampled here by clk, which runs much faster than mem_clk.
`timescale 1ns/1ns
`default_nettype none

module sdpmt_core #(
    parameter int DATA_W = sdpmt_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Memory-side pins, asynchronous to clk
    input wire logic mem_clk,
    input wire logic cke,
    input wire logic dqm,
    input wire logic [DATA_W-1:0] dq_in,
    // Array-side status
    input wire logic all_banks_idle,
    input wire logic burst_active,
    input wire logic read_cycle,
    input wire logic write_cycle,
    input wire logic [DATA_W-1:0] rd_data,
    // Array-side outputs
    output logic int_clk_tick,
    output logic wr_strobe,
    output logic [DATA_W-1:0] wr_data,
    output logic buffers_on,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic in_power_down
);
    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [1:0] clk_sync_ff;
    logic [1:0] cke_sync_ff;
    logic [1:0] dqm_sync_ff;
    logic [DATA_W-1:0] dq_s1_ff;
    logic [DATA_W-1:0] dq_s2_ff;
    logic mclk_prev_ff;
    logic cke_prev_ff;
    logic mclk_rise;
    sdpmt_pkg::sdpmt_state_t state_ff;
    sdpmt_pkg::sdpmt_state_t nxt_state;

    // Two stages for every pin; the first stage feeds only the second.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Reset high, so a memory clock that is already high at release
            // is not taken for a rise; only a real low-to-high counts.
            clk_sync_ff <= 2'h3;
            cke_sync_ff <= {2{sdpmt_pkg::RST_CKE}};
            dqm_sync_ff <= {2{sdpmt_pkg::RST_DQM}};
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[0], mem_clk};
            cke_sync_ff <= {cke_sync_ff[0], cke};
            dqm_sync_ff <= {dqm_sync_ff[0], dqm};
            dq_s1_ff <= dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // Edge history of the memory clock and the clock-enable sample.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mclk_prev_ff <= 1'b1;
            cke_prev_ff <= sdpmt_pkg::RST_CKE;
        end else begin
            mclk_prev_ff <= clk_sync_ff[1];
            if (mclk_rise) begin
                cke_prev_ff <= cke_sync_ff[1];
            end
        end
    end

    assign mclk_rise = clk_sync_ff[1] & ~mclk_prev_ff;

    // ------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------
    // Clock enable is judged only at memory clock rises, as the pins are.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sdpmt_pkg::SDPMT_ACTIVE: begin
                if (mclk_rise && !cke_sync_ff[1]) begin
                    if (all_banks_idle) begin
                        nxt_state = sdpmt_pkg::SDPMT_PDOWN;
                    end else if (burst_active) begin
                        nxt_state = sdpmt_pkg::SDPMT_SUSPEND;
                    end
                end
            end
            sdpmt_pkg::SDPMT_SUSPEND: begin
                if (mclk_rise && cke_sync_ff[1]) begin
                    nxt_state = sdpmt_pkg::SDPMT_ACTIVE;
                end
            end
            sdpmt_pkg::SDPMT_PDOWN: begin
                if (mclk_rise && cke_sync_ff[1]) begin
                    nxt_state = sdpmt_pkg::SDPMT_ACTIVE;
                end
            end
            default: nxt_state = sdpmt_pkg::SDPMT_ACTIVE;
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= sdpmt_pkg::SDPMT_ACTIVE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Internal clock tick and buffer enable. Clock enable acts one memory
    // clock late: the rise that samples it low still ticks, and the exit
    // rise gives no tick, so the internal clock resumes on the rise after.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_clk_tick <= 1'b0;
            buffers_on <= 1'b1;
            in_power_down <= 1'b0;
        end else begin
            int_clk_tick <= mclk_rise && cke_prev_ff &&
                            (state_ff == sdpmt_pkg::SDPMT_ACTIVE);
            buffers_on <= (nxt_state != sdpmt_pkg::SDPMT_PDOWN);
            in_power_down <= (nxt_state == sdpmt_pkg::SDPMT_PDOWN);
        end
    end

    // ------------------------------------------------------------------
    // Byte mask
    // ------------------------------------------------------------------
    // Write data is taken at memory clock rises; masked words never strobe.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_strobe <= 1'b0;
            wr_data <= '0;
        end else begin
            wr_strobe <= mclk_rise && write_cycle && !dqm_sync_ff[1] &&
                         (state_ff == sdpmt_pkg::SDPMT_ACTIVE);
            if (mclk_rise && !dqm_sync_ff[1]) begin
                wr_data <= dq_s2_ff;
            end
        end
    end

    // Output drivers follow the mask during reads; enable is active low.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dq_out <= '0;
            dq_oe_n <= 1'b1;
        end else begin
            dq_out <= rd_data;
            dq_oe_n <= !(read_cycle && !dqm_sync_ff[1] &&
                         (nxt_state != sdpmt_pkg::SDPMT_PDOWN));
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_exit_pd;
        state_ff == sdpmt_pkg::SDPMT_PDOWN ##1
        state_ff == sdpmt_pkg::SDPMT_ACTIVE;
    endsequence

    AST_PD_BUFFERS_BACK: assert property (
        @(posedge clk) disable iff (!resetn)
        s_exit_pd |-> buffers_on)
        else $error("Buffers not on after power-down exit.");

    AST_PD_BUFFERS_OFF: assert property (
        @(posedge clk) disable iff (!resetn)
        state_ff == sdpmt_pkg::SDPMT_PDOWN |-> !buffers_on && in_power_down)
        else $error("Buffers on during power-down.");

    AST_NO_TICK_SUSPEND: assert property (
        @(posedge clk) disable iff (!resetn)
        $past(state_ff) != sdpmt_pkg::SDPMT_ACTIVE |-> !int_clk_tick)
        else $error("Internal clock ticked while suspended.");

    AST_ENTER_PD: assert property (
        @(posedge clk) disable iff (!resetn)
        state_ff == sdpmt_pkg::SDPMT_ACTIVE && mclk_rise &&
        !cke_sync_ff[1] && all_banks_idle
        |=> state_ff == sdpmt_pkg::SDPMT_PDOWN)
        else $error("Idle clock-enable drop did not enter power-down.");

    AST_SUSPEND_EXIT: assert property (
        @(posedge clk) disable iff (!resetn)
        state_ff == sdpmt_pkg::SDPMT_SUSPEND && mclk_rise && cke_sync_ff[1]
        |=> state_ff == sdpmt_pkg::SDPMT_ACTIVE)
        else $error("Suspend not left when clock enable rose.");

    AST_MASK_WRITE: assert property (
        @(posedge clk) disable iff (!resetn)
        mclk_rise && write_cycle && dqm_sync_ff[1] |=> !wr_strobe)
        else $error("Masked write word was stored.");

    AST_WRITE_STORE: assert property (
        @(posedge clk) disable iff (!resetn)
        mclk_rise && write_cycle && !dqm_sync_ff[1] &&
        state_ff == sdpmt_pkg::SDPMT_ACTIVE
        |=> wr_strobe && wr_data == $past(dq_s2_ff))
        else $error("Unmasked write word was not stored.");

    AST_READ_MASK_HIZ: assert property (
        @(posedge clk) disable iff (!resetn)
        read_cycle && dqm_sync_ff[1] |=> dq_oe_n)
        else $error("Drivers on while read mask high.");
endmodule

`default_nettype wire

// file: rtl/sdpmt_pkg.sv
// Package for the SDRAM power-down, clock-suspend and byte-mask block.
// Assumes a single 100 MHz system clock that oversamples the memory clock.
package sdpmt_pkg;
    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam logic RST_CKE = 1'b0;
    localparam logic RST_DQM = 1'b1;
    // ------------------------------------------------------------------
    // Timing figures, controller side, nanoseconds per grade; refresh spacing also in clk cycles
    // ------------------------------------------------------------------
    localparam int SYS_CLK_NS = 10;
    localparam int ROW_CYCLE_NS_FAST = 55;
    localparam int ROW_CYCLE_NS_MID = 60;
    localparam int ROW_CYCLE_NS_SLOW = 63;
    localparam int CROSS_BANK_ACTIVATE_GAP_NS = 10;
    localparam int MODE_SET_WAIT_NS = 10;
    localparam int AVERAGE_REFRESH_SPACING_NS = 7800;
    localparam int AVERAGE_REFRESH_SPACING_CYC =
        AVERAGE_REFRESH_SPACING_NS / SYS_CLK_NS;
    // ------------------------------------------------------------------
    // Power states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SDPMT_ACTIVE  = 3'b001,
        SDPMT_SUSPEND = 3'b010,
        SDPMT_PDOWN   = 3'b100
    } sdpmt_state_t;
endpackage

// file: test/sdpmt_ctrl_model.sv
// Controller-side model: makes the memory clock and drives the pins.
// Assumes the bench sets its request inputs before each falling edge.
`timescale 1ns/1ns
`default_nettype none
module sdpmt_ctrl_model (
    // Bench clock
    input wire logic clk,
    // Requests from the bench
    input wire logic req_cke,
    input wire logic req_dqm,
    input wire logic req_drive,
    input wire logic [7:0] req_dq,
    // Pins towards the device
    output logic mem_clk,
    output logic cke,
    output logic dqm,
    output logic [7:0] dq_in
);
    // Free-running 125 ns memory clock, phase unrelated to clk.
    initial begin
        mem_clk = 1'b0;
        forever begin
            #62 mem_clk = 1'b1;
            #63 mem_clk = 1'b0;
        end
    end
    // Exit hold rounded up to whole memory clocks, and the longest run of
    // clock enable low that the refresh period allows.
    localparam int MCLK_PS = 125000;
    localparam int SETUP_PS = 1500;
    localparam int MCLK_NS = 125;
    localparam int REFRESH_PERIOD_NS = 64000000;
    localparam int CKE_LOW_MAX = REFRESH_PERIOD_NS / MCLK_NS;
    function automatic int ps_to_mclk(input int ps);
        return (ps + MCLK_PS - 1) / MCLK_PS;
    endfunction
    localparam int POWER_DOWN_EXIT_WAIT = ps_to_mclk(SETUP_PS + MCLK_PS);
    int low_run = 0;
    int high_run = 0;
    // Pins move half a memory clock before the sampling rise, so they hold
    // across it; a released data line toggles so no stale word survives.
    // The extra step off the falling edge keeps the clk edge unambiguous.
    initial begin
        cke = 1'b0;
        dqm = 1'b1;
        dq_in = 8'h00;
        forever begin
            @(negedge mem_clk);
            #1;
            @(posedge clk);
            #1;
            // Clock enable stays up for the exit wait once raised, and is
            // forced up before the refresh period could run out.
            cke = req_cke ||
                  (low_run >= CKE_LOW_MAX) ||
                  (cke && (high_run < POWER_DOWN_EXIT_WAIT));
            high_run = cke ? high_run + 1 : 0;
            low_run = cke ? 0 : low_run + 1;
            // Only no-op commands are ever presented, so every command
            // spacing holds for any grade.
            dqm = req_dqm;
            dq_in = req_drive ? req_dq : ~dq_in;
        end
    end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the power state and byte mask block.
// Assumes the controller model above and a 100 MHz bench clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, idle = 1'b1, burst = 1'b0;
    logic rd = 1'b0, wr = 1'b0, r_cke = 1'b0, r_dqm = 1'b1, r_drv = 1'b0;
    logic [7:0] r_dq = 8'h00, rd_data = 8'h00, m_dq, wr_data, dq_out;
    logic mem_clk, cke, dqm, tick, wr_strobe, buf_on, oe_n, pd;
    logic [15:0] lf = 16'h86C6;
    logic [7:0] exp_q[$];
    int errors = 0, cmp_count = 0, ticks = 0, n;
    // Clock.
    always #5 clk = ~clk;
    sdpmt_ctrl_model PART (.clk(clk), .req_cke(r_cke), .req_dqm(r_dqm),
        .req_drive(r_drv), .req_dq(r_dq), .mem_clk(mem_clk), .cke(cke),
        .dqm(dqm), .dq_in(m_dq));
    sdpmt_core DUT (.clk(clk), .resetn(resetn), .mem_clk(mem_clk),
        .cke(cke), .dqm(dqm), .dq_in(m_dq), .all_banks_idle(idle),
        .burst_active(burst), .read_cycle(rd), .write_cycle(wr),
        .rd_data(rd_data), .int_clk_tick(tick), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .buffers_on(buf_on), .dq_out(dq_out),
        .dq_oe_n(oe_n), .in_power_down(pd));
    // Pseudo-random words; a fixed seed keeps runs repeatable.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic mode(input logic i, b, r, w);
        @(posedge clk);
        #1;
        {idle, burst, rd, wr} = {i, b, r, w};
    endtask
    // One memory clock: the model drives the pins after the falling edge,
    // the device takes them at the rise, and the task returns just after
    // a clk edge once the answer and its tick count have settled.
    task automatic step(input logic c, m, d);
        r_cke = c;
        r_dqm = m;
        r_drv = d;
        lf = lfsr(lf);
        r_dq = lf[7:0];
        if (d && !m && wr) exp_q.push_back(lf[7:0]);
        @(negedge mem_clk);
        @(posedge mem_clk);
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Counts internal clock pulses and checks each stored word in order.
    always @(posedge clk) begin
        if (tick === 1'b1) ticks++;
        if (wr_strobe === 1'b1) begin
            if (exp_q.size() == 0) chk(8'hFF, 8'h00);
            else chk(wr_data, exp_q.pop_front());
        end
    end
    // Watchdog against a hang.
    initial begin
        #20000;
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end
    // Main sequence: run, write, read, power-down, suspend.
    initial begin
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (2) step(1, 1, 0);
        n = ticks;
        repeat (2) step(1, 1, 0);
        chk(8'(ticks - n), 8'h02);
        mode(1, 0, 0, 1);
        for (int i = 0; i < 8; i++) step(1, i[0], 1);
        step(1, 1, 0);
        mode(1, 0, 1, 0);
        rd_data = lf[15:8];
        for (int i = 0; i < 5; i++) begin
            step(1, (i == 4) | i[0], 0);
            chk({7'h00, oe_n}, {7'h00, (i == 4) | i[0]});
        end
        chk(dq_out, rd_data);
        mode(1, 0, 0, 0);
        n = ticks;
        step(0, 1, 0);
        chk(8'(ticks - n), 8'h01);
        n = ticks;
        step(0, 1, 0);
        chk({5'h00, buf_on, pd, oe_n}, 8'h03);
        step(1, 1, 0);
        chk({6'h00, buf_on, pd}, 8'h02);
        chk(8'(ticks - n), 8'h00);
        n = ticks;
        step(1, 1, 0);
        chk(8'(ticks - n), 8'h01);
        mode(0, 1, 0, 0);
        step(1, 1, 0);
        n = ticks;
        step(0, 1, 0);
        chk(8'(ticks - n), 8'h01);
        n = ticks;
        step(0, 1, 0);
        chk({7'h00, pd}, 8'h00);
        step(1, 1, 0);
        chk(8'(ticks - n), 8'h00);
        n = ticks;
        step(1, 1, 0);
        chk(8'(ticks - n), 8'h01);
        chk(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule
`default_nettype wire
